// [logic/lcb_decoder.sv]
// Purpose: Command decoder, status registers, data pointer and blink generator
// Assumes: One byte strobe per received byte, frame start pulse per transfer
// Notes: Blink timing counts display clock ticks given as an enable
// Function
// - Bit 7 marks another command follows
// - After clear flag, bytes become display data
// - Recognise commands by fixed high bits
// - Drive field selects backplane configuration
// - Bias bit selects third or half bias
// - Enable bit blanks display, bit 4 ignored
// - Pointer load copies low five bits
// - Subaddress command copies low three bits
// - Bank bit 1 picks input storage rows
// - Bank bit 0 picks displayed rows
// - Bank command ignored in three/four-way
// - Blink field selects off or mode
// - Blink divides display clock 768/1536/3072
// - Nominal 1536 Hz gives 2/1/0.5 Hz
// - Blink bit 2 picks whole or alternate
// - Alternate blink swaps displayed bank periodically
// - Three/four-way forces whole-display blinking
// - Apply commands, store data in order
// - Pointer advances 8, 4, 3 or 2
// - Store only on subaddress match, advance anyway
`timescale 1ns/1ns
module lcb_decoder (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Received bytes
    input wire logic frame_start,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    // Display clock tick and subaddress pins
    input wire logic disp_tick,
    input wire logic hw_subaddr_pin0,
    input wire logic [1:0] hw_subaddr_hi,
    // Status
    output lcb_pkg::lcb_status_s status,
    output logic [4:0] data_ptr,
    output logic [2:0] subaddr_cnt,
    output logic in_data_phase,
    // RAM write
    output logic ram_we,
    output logic [4:0] ram_addr,
    output logic [7:0] ram_wdata,
    output logic [1:0] ram_drive,
    output logic ram_in_bank,
    // Display output control
    output logic display_on,
    output logic shown_bank
);
    lcb_pkg::lcb_phase_e phase, next_phase;
    lcb_pkg::lcb_status_s next_status;
    logic [4:0] next_ptr;
    logic [2:0] next_sub;
    logic [lcb_pkg::HALF_DIV_W-1:0] div_cnt, next_div_cnt;
    logic blink_phase, next_blink_phase;
    logic next_we;
    logic [4:0] next_addr;
    logic [7:0] next_wdata;
    logic [5:0] ptr_sum;
    logic [lcb_pkg::HALF_DIV_W-1:0] half_div;

    function automatic logic [4:0] ptr_step(input lcb_pkg::lcb_drive_e d);
        unique case (d)
            lcb_pkg::LCB_STATIC: ptr_step = lcb_pkg::STEP_STATIC;
            lcb_pkg::LCB_MUX2: ptr_step = lcb_pkg::STEP_MUX2;
            lcb_pkg::LCB_MUX3: ptr_step = lcb_pkg::STEP_MUX3;
            lcb_pkg::LCB_MUX4: ptr_step = lcb_pkg::STEP_MUX4;
        endcase
    endfunction : ptr_step

    function automatic logic has_alt_bank(input lcb_pkg::lcb_drive_e d);
        has_alt_bank = (d == lcb_pkg::LCB_STATIC) || (d == lcb_pkg::LCB_MUX2);
    endfunction : has_alt_bank

    // Blink toggles every half period, so a full cycle equals the divide ratio
    always_comb begin
        unique case (status.blink_rate_sel)
            2'h1: half_div = lcb_pkg::HALF_DIV_W'(lcb_pkg::BLINK_DIV1 / 2 - 1);
            2'h2: half_div = lcb_pkg::HALF_DIV_W'(lcb_pkg::BLINK_DIV2 / 2 - 1);
            2'h3: half_div = lcb_pkg::HALF_DIV_W'(lcb_pkg::BLINK_DIV3 / 2 - 1);
            default: half_div = '0;
        endcase
    end

    always_comb begin
        next_phase = phase;
        next_status = status;
        next_ptr = data_ptr;
        next_sub = subaddr_cnt;
        next_we = 1'b0;
        next_addr = ram_addr;
        next_wdata = ram_wdata;
        ptr_sum = {1'b0, data_ptr} + {1'b0, ptr_step(status.drive)};
        if (frame_start) begin
            next_phase = lcb_pkg::LCB_CMD;
        end else if (byte_valid && phase == lcb_pkg::LCB_DATA) begin
            if (subaddr_cnt == {hw_subaddr_hi, hw_subaddr_pin0}) begin
                next_we = 1'b1;
                next_addr = data_ptr;
                next_wdata = byte_data;
            end
            next_ptr = ptr_sum[4:0];
            if (ptr_sum[5]) begin
                next_sub = subaddr_cnt + 3'h1;
            end
        end else if (byte_valid) begin
            if (!byte_data[lcb_pkg::CONT_BIT]) begin
                next_phase = lcb_pkg::LCB_DATA;
            end
            if (byte_data[6:5] == lcb_pkg::MODE_PAT) begin
                next_status.display_en = byte_data[lcb_pkg::EN_BIT];
                next_status.half_bias = byte_data[lcb_pkg::BIAS_BIT];
                next_status.drive = lcb_pkg::lcb_drive_e'(byte_data[1:0]);
            end else if (byte_data[6:5] == lcb_pkg::PTR_PAT) begin
                next_ptr = byte_data[4:0];
            end else if (byte_data[6:3] == lcb_pkg::SUB_PAT) begin
                next_sub = byte_data[2:0];
            end else if (byte_data[6:2] == lcb_pkg::BANK_PAT) begin
                if (has_alt_bank(status.drive)) begin
                    next_status.in_bank = byte_data[lcb_pkg::IBANK_BIT];
                    next_status.out_bank = byte_data[lcb_pkg::OBANK_BIT];
                end
            end else if (byte_data[6:3] == lcb_pkg::BLINK_PAT) begin
                next_status.alt_bank_blink = byte_data[lcb_pkg::AB_BIT];
                next_status.blink_rate_sel = byte_data[1:0];
            end
        end
    end

    // Divider restarts when blinking is off so the first half period is full
    always_comb begin
        next_div_cnt = div_cnt;
        next_blink_phase = blink_phase;
        if (status.blink_rate_sel == 2'h0) begin
            next_div_cnt = '0;
            next_blink_phase = 1'b0;
        end else if (disp_tick) begin
            if (div_cnt >= half_div) begin
                next_div_cnt = '0;
                next_blink_phase = ~blink_phase;
            end else begin
                next_div_cnt = div_cnt + 1'b1;
            end
        end
    end

    // Decoder state: phase, status, pointer and subaddress counter
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= lcb_pkg::LCB_CMD;
            status <= lcb_pkg::STATUS_RST;
            data_ptr <= '0;
            subaddr_cnt <= '0;
        end else if (clk_en) begin
            phase <= next_phase;
            status <= next_status;
            data_ptr <= next_ptr;
            subaddr_cnt <= next_sub;
        end
    end

    // RAM write port, registered so address and data settle with the strobe
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ram_we <= 1'b0;
            ram_addr <= '0;
            ram_wdata <= '0;
        end else if (clk_en) begin
            ram_we <= next_we;
            ram_addr <= next_addr;
            ram_wdata <= next_wdata;
        end
    end

    // Blink divider
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= '0;
            blink_phase <= 1'b0;
        end else if (clk_en) begin
            div_cnt <= next_div_cnt;
            blink_phase <= next_blink_phase;
        end
    end

    // Host-side element blinking in three/four-way is done by RAM rewrites
    logic alt_mode;
    assign alt_mode = status.alt_bank_blink && has_alt_bank(status.drive);
    assign display_on = status.display_en && !(blink_phase && !alt_mode);
    assign shown_bank = status.out_bank ^ (blink_phase && alt_mode);
    assign in_data_phase = (phase == lcb_pkg::LCB_DATA);
    assign ram_drive = status.drive;
    assign ram_in_bank = status.in_bank;
endmodule : lcb_decoder

// [logic/lcb_pkg.sv]
// Purpose: Shared constants and types for the LCD command decoder and blink block
// Assumes: Byte-level interface, bus framing handled elsewhere
// Notes: Drive mode codes follow the mode command field
package lcb_pkg;
    localparam int CONT_BIT = 7;
    localparam logic [1:0] MODE_PAT = 2'h2;
    localparam logic [1:0] PTR_PAT = 2'h0;
    localparam logic [3:0] SUB_PAT = 4'hc;
    localparam logic [4:0] BANK_PAT = 5'h1e;
    localparam logic [3:0] BLINK_PAT = 4'he;
    localparam int EN_BIT = 3;
    localparam int BIAS_BIT = 2;
    localparam int IBANK_BIT = 1;
    localparam int OBANK_BIT = 0;
    localparam int AB_BIT = 2;
    localparam logic [4:0] STEP_STATIC = 5'h08;
    localparam logic [4:0] STEP_MUX2 = 5'h04;
    localparam logic [4:0] STEP_MUX3 = 5'h03;
    localparam logic [4:0] STEP_MUX4 = 5'h02;
    localparam int BLINK_DIV1 = 768;
    localparam int BLINK_DIV2 = 1536;
    localparam int BLINK_DIV3 = 3072;
    localparam int NOMINAL_FCLK_HZ = 1536;
    localparam int HALF_DIV_W = 11;

    typedef enum logic [1:0] {
        LCB_MUX4 = 2'h0,
        LCB_STATIC = 2'h1,
        LCB_MUX2 = 2'h2,
        LCB_MUX3 = 2'h3
    } lcb_drive_e;

    typedef struct packed {
        logic display_en;
        logic half_bias;
        lcb_drive_e drive;
        logic in_bank;
        logic out_bank;
        logic alt_bank_blink;
        logic [1:0] blink_rate_sel;
    } lcb_status_s;

    localparam lcb_status_s STATUS_RST = '{1'b0, 1'b0, LCB_MUX4, 1'b0, 1'b0, 1'b0, 2'h0};

    typedef enum logic {
        LCB_CMD = 1'b0,
        LCB_DATA = 1'b1
    } lcb_phase_e;
endpackage : lcb_pkg

// [verification/lcb_decoder_asserts.sv]
// Purpose: Port checks for the LCD command decoder
// Assumes: Single clock, async reset
// Notes: Bound after endmodule
`timescale 1ns/1ns
module lcb_decoder_asserts (
    // Watched ports
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic frame_start,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic hw_subaddr_pin0,
    input wire logic [1:0] hw_subaddr_hi,
    input wire lcb_pkg::lcb_status_s status,
    input wire logic [4:0] data_ptr,
    input wire logic [2:0] subaddr_cnt,
    input wire logic in_data_phase,
    input wire logic ram_we
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    logic cmd, dat;
    assign cmd = clk_en && byte_valid && !frame_start && !in_data_phase;
    assign dat = clk_en && byte_valid && !frame_start && in_data_phase;
    a_data_entry: assert property (cmd && !byte_data[7] |=> in_data_phase)
        else $error("no data phase");
    a_mode_load: assert property (cmd && byte_data[6:5] == 2'h2
        |=> status.drive == $past(byte_data[1:0])) else $error("bad drive");
    a_ptr_load: assert property (cmd && byte_data[6:5] == 2'h0
        |=> data_ptr == $past(byte_data[4:0])) else $error("bad pointer");
    a_sub_load: assert property (cmd && byte_data[6:3] == 4'hc
        |=> subaddr_cnt == $past(byte_data[2:0])) else $error("bad subaddress");
    // Three and four way codes have equal bits
    a_bank_ignore: assert property (cmd && byte_data[6:2] == 5'h1e
        && status.drive[1] == status.drive[0] |=> $stable(status)) else $error("bank used");
    a_mux4_step: assert property (dat && status.drive == lcb_pkg::LCB_MUX4
        |=> data_ptr == $past(data_ptr) + 5'h02) else $error("bad step");
    a_store_match: assert property (dat && subaddr_cnt == {hw_subaddr_hi, hw_subaddr_pin0}
        |=> ram_we) else $error("store missing");
    a_unknown_hold: assert property (cmd && (byte_data[6:5] == 2'h1
        || byte_data[6:3] == 4'hd || byte_data[6:2] == 5'h1f)
        |=> $stable(status) && $stable(data_ptr)) else $error("unknown obeyed");
    c_store: cover property (dat && ram_we);
    c_alt: cover property (status.alt_bank_blink && status.blink_rate_sel != 2'h0);
    c_bank: cover property (cmd && byte_data[6:2] == 5'h1e);
endmodule : lcb_decoder_asserts
bind lcb_decoder lcb_decoder_asserts u_chk (.*);

// [verification/lcb_host_model.sv]
// Purpose: Host that frames transfers and sends bytes
// Assumes: Bus framing already reduced to strobes
// Notes: Idle data shows the inverse of the last byte
`timescale 1ns/1ns
module lcb_host_model (
    // Clock in, bytes out
    input wire logic core_clk,
    output logic frame_start,
    output logic byte_valid,
    output logic [7:0] byte_data
);
    initial {frame_start, byte_valid, byte_data} = 10'h000;
    task automatic frame();
        @(negedge core_clk) frame_start = 1'b1;
        @(negedge core_clk) frame_start = 1'b0;
    endtask : frame
    // Element blinking by rewrites is up to the caller
    task automatic send(input logic [7:0] b);
        @(negedge core_clk) byte_valid = 1'b1;
        byte_data = b;
        @(negedge core_clk) byte_valid = 1'b0;
        byte_data = ~b;
    endtask : send
endmodule : lcb_host_model

// [verification/lcb_decoder_test.sv]
// Purpose: Self-checking bench for the LCD command decoder
// Assumes: Host model drives bytes at falling edges
// Notes: Subaddress pins start at 3 and are moved in the last scenario
`timescale 1ns/1ns
module lcb_decoder_test;
    logic core_clk = 1'b0, arst_n = 1'b0, disp_tick = 1'b0, clk_en = 1'b1;
    logic hw_subaddr_pin0 = 1'b1;
    logic [1:0] hw_subaddr_hi = 2'h1, ram_drive;
    logic frame_start, byte_valid, in_data_phase, ram_we, ram_in_bank, display_on, shown_bank;
    logic [7:0] byte_data, ram_wdata;
    logic [4:0] data_ptr, ram_addr;
    logic [2:0] subaddr_cnt;
    lcb_pkg::lcb_status_s status, st;
    int n_fail = 0, samples_checked = 0, cycles = 0;
    always #2 core_clk = ~core_clk;
    lcb_host_model host (.*);
    lcb_decoder dut (.*);
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge core_clk) disp_tick = 1'b1;
            @(negedge core_clk) disp_tick = 1'b0;
        end
    endtask : ticks
    task automatic t_load();
        chk(status, lcb_pkg::STATUS_RST);
        host.frame();
        host.send(8'hd9);
        host.send(8'h85);
        host.send(8'he3);
        host.send(8'hfb);
        host.send(8'h70);
        chk({status.display_en, status.drive, ram_drive, in_data_phase}, 6'h2b);
        chk({data_ptr, subaddr_cnt, status.in_bank, status.out_bank}, 10'h0af);
        chk(ram_in_bank, 1'b1);
        host.send(8'ha5);
        chk({ram_we, ram_addr, ram_wdata, data_ptr}, 19'h4b4ad);
        host.frame();
        host.send(8'h62);
        host.send(8'he2);
        chk({ram_we, subaddr_cnt, data_ptr}, 9'h055);
        host.send(8'h00);
        host.send(8'h00);
        chk({subaddr_cnt, data_ptr}, 8'h65);
        $display("t_load done");
    endtask : t_load
    task automatic t_modes();
        for (int i = 0; i < 4; i++) begin
            host.frame();
            host.send({5'h09, i[0], i[1:0]});
            chk({status.half_bias, status.drive}, {i[0], i[1:0]});
        end
        st = status;
        host.frame();
        host.send(8'hf8);
        host.send(8'h20);
        chk(status, st);
        $display("t_modes done");
    endtask : t_modes
    task automatic t_blink();
        host.frame();
        host.send(8'hc9);
        host.send(8'hf8);
        host.send(8'h75);
        chk({status.alt_bank_blink, status.blink_rate_sel, shown_bank}, 4'ha);
        ticks(380);
        chk(shown_bank, 1'b0);
        ticks(10);
        chk({shown_bank, display_on}, 2'h3);
        host.frame();
        host.send(8'h48);
        chk({shown_bank, display_on}, 2'h0);
        host.send(8'h00);
        chk(data_ptr, 5'h07);
        $display("t_blink done");
    endtask : t_blink
    task automatic t_pins();
        logic [4:0] p;
        st = status;
        p = data_ptr;
        @(negedge core_clk) clk_en = 1'b0;
        host.frame();
        host.send(8'h42);
        host.send(8'h5a);
        chk({status, data_ptr, ram_we}, {st, p, 1'b0});
        @(negedge core_clk) clk_en = 1'b1;
        hw_subaddr_hi = 2'h2;
        hw_subaddr_pin0 = 1'b0;
        host.frame();
        host.send(8'h64);
        host.send(8'h3c);
        chk({ram_we, ram_addr, ram_wdata, data_ptr}, {1'b1, 5'h07, 8'h3c, 5'h09});
        hw_subaddr_pin0 = 1'b1;
        host.send(8'hc3);
        chk({ram_we, subaddr_cnt, data_ptr}, {1'b0, 3'h4, 5'h0b});
        $display("t_pins done");
    endtask : t_pins
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        @(negedge core_clk) arst_n = 1'b1;
        t_load();
        t_modes();
        t_blink();
        t_pins();
        final_report();
    end
endmodule : lcb_decoder_test
